// ==== spss_defines.vh ====
// constants for the system power state sequencer
`ifndef SPSS_DEFINES_VH
`define SPSS_DEFINES_VH
`define SPSS_REG_CHIP_REV      6'h00
`define SPSS_REG_STATUS_SET    6'h01
`define SPSS_REG_GEN_STATUS    6'h05
`define SPSS_REG_CTRL          6'h02
`define SPSS_CHIP_REV_RST      16'h0000
`define SPSS_STATUS_RST        16'h0000
`define SPSS_BIT_WD2           7
`define SPSS_BIT_WD1           6
`define SPSS_BIT_STATE_CHG     5
`define SPSS_BIT_VXPG          3
`define SPSS_BIT_TEMP_WARN     2
`define SPSS_BIT_TEMP_ERR      1
`define SPSS_BIT_PON_LOW       0
`define SPSS_BIT_PARITY        12
`define SPSS_BIT_CKSUM3        10
`define SPSS_BIT_CKSUM2        9
`define SPSS_BIT_CKSUM1        8
`define SPSS_CTRL_CYCLE        0
`define SPSS_CTRL_PARK         1
`define SPSS_CTRL_MIRROR_EN    2
`define SPSS_CTRL_MIRROR_DONE  3
`define SPSS_CTRL_ILLUM        4
`define SPSS_CTRL_WD_EN        5
`define SPSS_CTRL_HEADLIGHT    6
`define SPSS_ST_SHUTDOWN       5'h00
`define SPSS_ST_OFF            5'h02
`define SPSS_ST_INIT_1V1       5'h04
`define SPSS_ST_INIT_1V8       5'h05
`define SPSS_ST_INIT_3V3       5'h06
`define SPSS_ST_RESET_HOLD     5'h07
`define SPSS_ST_STANDBY        5'h08
`define SPSS_ST_MIRROR_UP      5'h09
`define SPSS_ST_DISP_READY     5'h0c
`define SPSS_ST_DISP_ON        5'h0d
`define SPSS_ST_PARK           5'h0e
`define SPSS_ST_PARK_DISCH     5'h11
`define SPSS_CAUSE_POWER_ON    3'h0
`define SPSS_CAUSE_PON_LOW     3'h1
`define SPSS_CAUSE_WD1         3'h2
`define SPSS_CAUSE_WD2         3'h3
`define SPSS_CAUSE_TEMP        3'h4
`define SPSS_CAUSE_SW_CYCLE    3'h5
`define SPSS_CLK_MHZ           20
`define SPSS_RAIL_STEP_US      100
`define SPSS_RAIL_STEP_CYC     (`SPSS_RAIL_STEP_US * `SPSS_CLK_MHZ)
`define SPSS_RESET_HOLD_US     100
`define SPSS_RESET_HOLD_CYC    (`SPSS_RESET_HOLD_US * `SPSS_CLK_MHZ)
`define SPSS_PARK_US           50
`define SPSS_PARK_CYC          (`SPSS_PARK_US * `SPSS_CLK_MHZ)
`define SPSS_DISCH_US          50
`define SPSS_DISCH_CYC         (`SPSS_DISCH_US * `SPSS_CLK_MHZ)
`define SPSS_FRAME_BITS        6'd32
`endif

// ==== spss_serial_slave.v ====
// serial slave shift engine for one spi port (mode 0, 32-bit frame)
`timescale 1ns/100ps
`default_nettype none
`include "spss_defines.vh"
module spss_serial_slave (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        sclk_pin,
   input  wire        sel_n_pin,
   input  wire        mosi_pin,
   output reg         miso_q,
   output reg  [5:0]  rd_addr_q,
   input  wire [15:0] rd_data,
   output reg         wr_stb_q,
   output reg         wr_en_q,
   output reg  [5:0]  wr_addr_q,
   output reg  [15:0] wr_data_q,
   output reg         par_err_q
);
   // frame: bit31 write flag, 30:25 address, 24 parity over 31:25, 23:16 zero,
   // 15:0 data; read data shifts out msb first during the data phase
   reg  [2:0]  clk_s_q;
   reg  [1:0]  sel_s_q;
   reg  [1:0]  dat_s_q;
   reg  [31:0] shift_q;
   reg  [5:0]  cnt_q;
   reg  [15:0] out_q;
   wire        rise;
   wire        fall;
   wire        sel_n;
   wire [31:0] nxt;

   assign rise  = clk_s_q[1] & ~clk_s_q[2];
   assign fall  = ~clk_s_q[1] & clk_s_q[2];
   assign sel_n = sel_s_q[1];
   assign nxt   = {shift_q[30:0], dat_s_q[1]};

   always @(posedge clk_sys) begin
      if (srst) begin
         clk_s_q   <= 3'h0;
         sel_s_q   <= 2'h3;
         dat_s_q   <= 2'h0;
         shift_q   <= 32'h0000_0000;
         cnt_q     <= 6'h00;
         out_q     <= 16'h0000;
         miso_q    <= 1'b0;
         rd_addr_q <= 6'h00;
         wr_stb_q  <= 1'b0;
         wr_en_q   <= 1'b0;
         wr_addr_q <= 6'h00;
         wr_data_q <= 16'h0000;
         par_err_q <= 1'b0;
      end else begin
         clk_s_q  <= {clk_s_q[1:0], sclk_pin};
         sel_s_q  <= {sel_s_q[0], sel_n_pin};
         dat_s_q  <= {dat_s_q[0], mosi_pin};
         wr_stb_q <= 1'b0;
         par_err_q <= 1'b0;
         if (sel_n) begin
            cnt_q  <= 6'h00; // frame ends when select rises
            miso_q <= 1'b0;
         end else if (rise) begin
            shift_q <= nxt; // sampled on rising clock edge
            cnt_q   <= cnt_q + 6'd1;
            if (cnt_q == 6'd6) begin
               rd_addr_q <= nxt[5:0];
            end
            if (cnt_q == 6'd15) begin
               out_q <= rd_data;
            end
            if (cnt_q == 6'd7 && (^nxt[7:0])) begin
               par_err_q <= 1'b1;
            end
            if (cnt_q == `SPSS_FRAME_BITS - 6'd1) begin
               // only a complete packet writes; partial frames are dropped
               wr_stb_q  <= 1'b1;
               wr_en_q   <= nxt[31];
               wr_addr_q <= nxt[30:25];
               wr_data_q <= nxt[15:0];
            end
         end else if (fall && cnt_q >= 6'd16 && cnt_q < `SPSS_FRAME_BITS) begin
            miso_q <= out_q[15];
            out_q  <= {out_q[14:0], 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// ==== spss_power_sequencer.v ====
// top-level system power state sequencer with two serial register ports
// Functional notes
// - reset puts machine in off, all supplies disabled, controller reset held low
// - leave off only with main supply good, power-on request high, no warning
// - enable external rails in order 1.1 V, 1.8 V, then 3.3 V
// - wait for all four monitored rails good before standby
// - hold controller reset low a fixed time, release entering standby
// - over-temperature error in standby goes to shutdown
// - standby returns to off on request low, sw cycle, watchdog, power loss
// - software enabling mirror voltages in standby moves to mirror power-up
// - software confirming mirror power-up moves to display ready
// - request low during mirror power-up waits until sequence finishes
// - head-up use: illumination toggles between display ready and active
// - headlight use never enters display active
// - park events from ready or active go to mirror park
// - park drives park request low, timers, regulators off, then standby
// - shutdown only on over-temperature, supplies off, exit on request low
// - monitor port is read-only, reads every register, works in shutdown
// - frames start on select low and end on select high
// - status bits 7, 6 watchdog errors, bit 0 request low
// - status bit 12 parity error, bits 10..8 checksum errors
// - status bit 5 set on every state change
// - bit 2 temperature warning, bit 1 error, error always forces park
// - five-bit state field: shutdown 0x00, off 0x02, standby 0x08
// - three-bit last-reset cause records why off was last entered
`timescale 1ns/100ps
`default_nettype none
`include "spss_defines.vh"
module spss_power_sequencer (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        power_on_request,
   input  wire        main_supply_good,
   input  wire        rail_1v1_good,
   input  wire        rail_1v8_good,
   input  wire        rail_3v3_good,
   input  wire        analog_six_volt_input_good,
   input  wire        die_temp_warning,
   input  wire        die_temp_error,
   input  wire        watchdog_one_error,
   input  wire        watchdog_two_error,
   input  wire        mirror_rail_power_fault,
   input  wire [2:0]  checksum_error,
   input  wire        primary_serial_clock,
   input  wire        primary_spi_select_n,
   input  wire        primary_serial_mosi,
   output wire        primary_serial_miso,
   input  wire        monitor_serial_clock,
   input  wire        monitor_spi_select_n,
   input  wire        monitor_serial_mosi,
   output wire        monitor_serial_miso,
   output reg         rail_1v1_en_q,
   output reg         rail_1v8_en_q,
   output reg         rail_3v3_en_q,
   output reg         mirror_reg_en_q,
   output reg         controller_reset_n_q,
   output reg         park_request_n_q,
   output reg         illumination_en_q
);
   parameter [15:0] CHIP_REVISION = 16'h0012; // arbitrary value
   parameter [15:0] RAIL_STEP_CYC = `SPSS_RAIL_STEP_CYC;
   parameter [15:0] RESET_HOLD_CYC = `SPSS_RESET_HOLD_CYC;
   parameter [15:0] PARK_CYC = `SPSS_PARK_CYC;
   parameter [15:0] DISCH_CYC = `SPSS_DISCH_CYC;

   localparam [4:0] ST_SHUTDOWN    = `SPSS_ST_SHUTDOWN;
   localparam [4:0] ST_OFF         = `SPSS_ST_OFF;
   localparam [4:0] ST_INIT_1V1    = `SPSS_ST_INIT_1V1;
   localparam [4:0] ST_INIT_1V8    = `SPSS_ST_INIT_1V8;
   localparam [4:0] ST_INIT_3V3    = `SPSS_ST_INIT_3V3;
   localparam [4:0] ST_RESET_HOLD  = `SPSS_ST_RESET_HOLD;
   localparam [4:0] ST_STANDBY     = `SPSS_ST_STANDBY;
   localparam [4:0] ST_MIRROR_UP   = `SPSS_ST_MIRROR_UP;
   localparam [4:0] ST_DISP_READY  = `SPSS_ST_DISP_READY;
   localparam [4:0] ST_DISP_ON     = `SPSS_ST_DISP_ON;
   localparam [4:0] ST_PARK        = `SPSS_ST_PARK;
   localparam [4:0] ST_PARK_DISCH  = `SPSS_ST_PARK_DISCH;

   // pin synchronisers; first stage read only by second stage
   reg  [10:0] sync1_q;
   reg  [10:0] sync2_q;
   reg  [2:0]  cks1_q;
   reg  [2:0]  cks2_q;
   wire        pon;
   wire        main_ok;
   wire        rails_ok;
   wire        t_warn;
   wire        t_err;
   wire        wd1;
   wire        wd2;
   wire        vxpg;

   always @(posedge clk_sys) begin
      if (srst) begin
         sync1_q <= 11'h000;
         sync2_q <= 11'h000;
         cks1_q  <= 3'h0;
         cks2_q  <= 3'h0;
      end else begin
         sync1_q <= {mirror_rail_power_fault, watchdog_two_error, watchdog_one_error,
                     die_temp_error, die_temp_warning, analog_six_volt_input_good,
                     rail_3v3_good, rail_1v8_good, rail_1v1_good, main_supply_good,
                     power_on_request};
         sync2_q <= sync1_q;
         cks1_q  <= checksum_error;
         cks2_q  <= cks1_q;
      end
   end

   assign pon      = sync2_q[0];
   assign main_ok  = sync2_q[1];
   assign rails_ok = &sync2_q[5:2];
   assign t_warn   = sync2_q[6];
   assign t_err    = sync2_q[7];
   assign wd1      = sync2_q[8];
   assign wd2      = sync2_q[9];
   assign vxpg     = sync2_q[10];

   // register ports
   wire [5:0]  p_rd_addr;
   wire [5:0]  m_rd_addr;
   wire        p_wr_stb;
   wire        p_wr_en;
   wire [5:0]  p_wr_addr;
   wire [15:0] p_wr_data;
   wire        p_par_err;
   reg  [15:0] status_q;
   reg  [6:0]  ctrl_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [2:0]  cause_q;
   reg  [2:0]  cause_d;
   reg  [15:0] timer_q;
   reg         cycle_q;
   reg         park_q;

   function [15:0] reg_read;
      input [5:0] addr;
      begin
         case (addr)
            `SPSS_REG_CHIP_REV:   reg_read = CHIP_REVISION;
            `SPSS_REG_STATUS_SET: reg_read = status_q;
            `SPSS_REG_CTRL:       reg_read = {9'h000, ctrl_q};
            `SPSS_REG_GEN_STATUS: reg_read = {8'h00, cause_q, state_q};
            default:              reg_read = 16'h0000;
         endcase
      end
   endfunction

   spss_serial_slave u_primary (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .sclk_pin  (primary_serial_clock),
      .sel_n_pin (primary_spi_select_n),
      .mosi_pin  (primary_serial_mosi),
      .miso_q    (primary_serial_miso),
      .rd_addr_q (p_rd_addr),
      .rd_data   (reg_read(p_rd_addr)),
      .wr_stb_q  (p_wr_stb),
      .wr_en_q   (p_wr_en),
      .wr_addr_q (p_wr_addr),
      .wr_data_q (p_wr_data),
      .par_err_q (p_par_err)
   );

   // monitor port: write outputs left open, read-only
   spss_serial_slave u_monitor (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .sclk_pin  (monitor_serial_clock),
      .sel_n_pin (monitor_spi_select_n),
      .mosi_pin  (monitor_serial_mosi),
      .miso_q    (monitor_serial_miso),
      .rd_addr_q (m_rd_addr),
      .rd_data   (reg_read(m_rd_addr)),
      .wr_stb_q  (),
      .wr_en_q   (),
      .wr_addr_q (),
      .wr_data_q (),
      .par_err_q ()
   );

   wire wr_ok = p_wr_stb & p_wr_en;
   wire wr_status = wr_ok & (p_wr_addr == `SPSS_REG_STATUS_SET);
   wire wr_ctrl = wr_ok & (p_wr_addr == `SPSS_REG_CTRL);
   wire [6:0] ctrl_now = wr_ctrl ? p_wr_data[6:0] : ctrl_q;
   wire wd_err = ctrl_q[`SPSS_CTRL_WD_EN] & (wd1 | wd2);
   wire park_evt = ~main_ok | ~rails_ok | ~pon | t_err | park_q | cycle_q;
   wire timer_done = (timer_q == 16'h0000);

   // control register: cycle and park commands are latched, cleared by use
   always @(posedge clk_sys) begin
      if (srst) begin
         ctrl_q  <= 7'h00;
         cycle_q <= 1'b0;
         park_q  <= 1'b0;
      end else begin
         ctrl_q <= {ctrl_now[6:2], 2'b00};
         if (wr_ctrl && p_wr_data[`SPSS_CTRL_CYCLE]) begin
            cycle_q <= 1'b1;
         end else if (state_q == ST_OFF) begin
            cycle_q <= 1'b0;
         end
         if (wr_ctrl && p_wr_data[`SPSS_CTRL_PARK]) begin
            park_q <= 1'b1;
         end else if (state_q == ST_PARK) begin
            park_q <= 1'b0;
         end
      end
   end

   // state machine
   always @* begin
      state_d = state_q;
      cause_d = cause_q;
      case (state_q)
         ST_SHUTDOWN: begin
            if (!pon) begin
               state_d = ST_OFF;
               cause_d = `SPSS_CAUSE_TEMP;
            end
         end
         ST_OFF: begin
            if (main_ok && pon && !t_warn) begin
               state_d = ST_INIT_1V1;
            end
         end
         ST_INIT_1V1: begin
            if (timer_done) begin
               state_d = ST_INIT_1V8;
            end
         end
         ST_INIT_1V8: begin
            if (timer_done) begin
               state_d = ST_INIT_3V3;
            end
         end
         ST_INIT_3V3: begin
            if (timer_done && rails_ok) begin
               state_d = ST_RESET_HOLD;
            end
         end
         ST_RESET_HOLD: begin
            if (timer_done) begin
               state_d = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (t_err) begin
               state_d = ST_SHUTDOWN;
            end else if (!pon || cycle_q || wd_err || !main_ok || !rails_ok) begin
               state_d = ST_OFF;
               if (!pon) begin
                  cause_d = `SPSS_CAUSE_PON_LOW;
               end else if (cycle_q) begin
                  cause_d = `SPSS_CAUSE_SW_CYCLE;
               end else if (wd_err && wd1) begin
                  cause_d = `SPSS_CAUSE_WD1;
               end else if (wd_err) begin
                  cause_d = `SPSS_CAUSE_WD2;
               end else begin
                  cause_d = `SPSS_CAUSE_POWER_ON;
               end
            end else if (ctrl_q[`SPSS_CTRL_MIRROR_EN]) begin
               state_d = ST_MIRROR_UP;
            end
         end
         ST_MIRROR_UP: begin
            // park events ignored until power-up completes
            if (ctrl_q[`SPSS_CTRL_MIRROR_DONE]) begin
               state_d = ST_DISP_READY;
            end
         end
         ST_DISP_READY: begin
            if (park_evt) begin
               state_d = ST_PARK;
            end else if (ctrl_q[`SPSS_CTRL_ILLUM] && !ctrl_q[`SPSS_CTRL_HEADLIGHT]) begin
               state_d = ST_DISP_ON;
            end
         end
         ST_DISP_ON: begin
            if (park_evt) begin
               state_d = ST_PARK;
            end else if (!ctrl_q[`SPSS_CTRL_ILLUM] || ctrl_q[`SPSS_CTRL_HEADLIGHT]) begin
               state_d = ST_DISP_READY;
            end
         end
         ST_PARK: begin
            if (timer_done) begin
               state_d = ST_PARK_DISCH;
            end
         end
         ST_PARK_DISCH: begin
            if (timer_done) begin
               state_d = ST_STANDBY;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_OFF;
         cause_q <= `SPSS_CAUSE_POWER_ON;
         timer_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         cause_q <= cause_d;
         if (state_d != state_q) begin
            case (state_d)
               ST_INIT_1V1:   timer_q <= RAIL_STEP_CYC;
               ST_INIT_1V8:   timer_q <= RAIL_STEP_CYC;
               ST_INIT_3V3:   timer_q <= RAIL_STEP_CYC;
               ST_RESET_HOLD: timer_q <= RESET_HOLD_CYC;
               ST_PARK:       timer_q <= PARK_CYC;
               ST_PARK_DISCH: timer_q <= DISCH_CYC;
               default:       timer_q <= 16'h0000;
            endcase
         end else if (!timer_done) begin
            timer_q <= timer_q - 16'd1;
         end
      end
   end

   // outputs; supplies drop in the same cycle reset or shutdown is seen
   always @(posedge clk_sys) begin
      if (srst) begin
         rail_1v1_en_q        <= 1'b0;
         rail_1v8_en_q        <= 1'b0;
         rail_3v3_en_q        <= 1'b0;
         mirror_reg_en_q      <= 1'b0;
         controller_reset_n_q <= 1'b0;
         park_request_n_q     <= 1'b1;
         illumination_en_q    <= 1'b0;
      end else begin
         rail_1v1_en_q <= (state_d >= ST_INIT_1V1) && (state_d != ST_OFF);
         rail_1v8_en_q <= (state_d >= ST_INIT_1V8);
         rail_3v3_en_q <= (state_d >= ST_INIT_3V3);
         controller_reset_n_q <= (state_d >= ST_STANDBY);
         mirror_reg_en_q <= (state_d >= ST_MIRROR_UP) && (state_d <= ST_PARK);
         // request held low through discharge too, so regulators never drop unparked
         park_request_n_q <= ~((state_d == ST_PARK) || (state_d == ST_PARK_DISCH) ||
                               t_err);
         illumination_en_q <= ctrl_q[`SPSS_CTRL_ILLUM] &&
                              ((state_d == ST_DISP_ON) ||
                               (state_d == ST_DISP_READY && ctrl_q[`SPSS_CTRL_HEADLIGHT]));
      end
   end

   // status set register: sticky, hardware set or write one to set
   always @(posedge clk_sys) begin
      if (srst) begin
         status_q <= `SPSS_STATUS_RST;
      end else begin
         // no clear path here; flags stay set until srst
         status_q <= status_q
                   | (wr_status ? p_wr_data : 16'h0000)
                   | ({15'h0000, wd2}          << `SPSS_BIT_WD2)
                   | ({15'h0000, wd1}          << `SPSS_BIT_WD1)
                   | ({15'h0000, state_d != state_q} << `SPSS_BIT_STATE_CHG)
                   | ({15'h0000, vxpg}         << `SPSS_BIT_VXPG)
                   | ({15'h0000, t_warn}       << `SPSS_BIT_TEMP_WARN)
                   | ({15'h0000, t_err}        << `SPSS_BIT_TEMP_ERR)
                   | ({15'h0000, ~pon}         << `SPSS_BIT_PON_LOW)
                   | ({15'h0000, p_par_err}    << `SPSS_BIT_PARITY)
                   | ({15'h0000, cks2_q[2]}    << `SPSS_BIT_CKSUM3)
                   | ({15'h0000, cks2_q[1]}    << `SPSS_BIT_CKSUM2)
                   | ({15'h0000, cks2_q[0]}    << `SPSS_BIT_CKSUM1);
      end
   end
endmodule
`default_nettype wire

// ==== spss_power_sequencer_checker.sv ====
// concurrent checks on the power state sequencer outputs
`timescale 1ns/100ps
`default_nettype none
module spss_power_sequencer_checker (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic power_on_request,
   input wire logic main_supply_good,
   input wire logic die_temp_warning,
   input wire logic die_temp_error,
   input wire logic rail_1v1_en_q,
   input wire logic rail_1v8_en_q,
   input wire logic rail_3v3_en_q,
   input wire logic mirror_reg_en_q,
   input wire logic controller_reset_n_q,
   input wire logic park_request_n_q,
   input wire logic illumination_en_q
);
   default clocking @(posedge clk_sys); endclocking
   // inputs pass a two-flop synchroniser, hence the margins below
   sequence s_hot;
      die_temp_error [*5];
   endsequence
   sequence s_gate;
      $past(power_on_request, 3) && $past(main_supply_good, 3) && !$past(die_temp_warning, 3);
   endsequence
   a_reset_all_off: assert property (srst |=> !rail_1v1_en_q && !rail_1v8_en_q
      && !rail_3v3_en_q && !mirror_reg_en_q && !controller_reset_n_q) else $error("not off");
   a_off_exit_gate: assert property (disable iff (srst)
      $rose(rail_1v1_en_q) |-> s_gate) else $error("left off state early");
   a_rail_first: assert property (disable iff (srst)
      $rose(rail_1v8_en_q) |-> rail_1v1_en_q && !rail_3v3_en_q) else $error("rail order");
   a_rail_last: assert property (disable iff (srst)
      $rose(rail_3v3_en_q) |-> rail_1v1_en_q && rail_1v8_en_q) else $error("rail order");
   a_ctrl_reset_hold: assert property (disable iff (srst)
      $rose(controller_reset_n_q) |-> $past(rail_3v3_en_q, 4)) else $error("reset too short");
   a_hot_parks: assert property (disable iff (srst)
      s_hot |-> !park_request_n_q) else $error("over-temperature not parked");
   a_illum_powered: assert property (disable iff (srst)
      illumination_en_q |-> mirror_reg_en_q && controller_reset_n_q) else $error("illum unpowered");
   a_regs_off_parked: assert property (disable iff (srst)
      $fell(mirror_reg_en_q) && !$past(srst) |-> !park_request_n_q) else $error("unparked off");
endmodule
bind spss_power_sequencer spss_power_sequencer_checker u_chk (.*);
`default_nettype wire

// ==== spss_spi_master.sv ====
// spi master model standing in for the controller processor
`timescale 1ns/100ps
`default_nettype none
module spss_spi_master (
   output var logic sclk,
   output var logic sel_n,
   output var logic mosi,
   input  wire logic miso
);
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b1;
   end
   // always a whole 32-bit packet: a cut frame is dropped by the slave
   task automatic xfer(input logic [31:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      sel_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         #200 sclk = 1'b1;
         if (i < 16) rx[i] = miso;
         #200 sclk = 1'b0;
      end
      #200 sel_n = 1'b1;
      mosi = ~mosi;
      #600;
   endtask
endmodule
`default_nettype wire

// ==== spss_power_sequencer_tb_top.sv ====
// self-checking testbench for the power state sequencer
`timescale 1ns/100ps
`default_nettype none
module spss_power_sequencer_tb_top;
   logic clk_sys = 1'b0, srst = 1'b1, pon = 1'b0, warn = 1'b0, hot = 1'b0;
   logic main_ok = 1'b1, sup_ok = 1'b1, vx = 1'b0, wd1 = 1'b0, wd2 = 1'b0;
   logic g11 = 1'b0, g18 = 1'b0, g33 = 1'b0, saw_park = 1'b0;
   logic [2:0] cks = 3'h0;
   wire p_ck, p_sel, p_mo, p_mi, m_ck, m_sel, m_mo, m_mi;
   wire r11, r18, r33, mreg, crst_n, park_n, illum;
   int num_errors = 0, cmp_count = 0;
   always #25 clk_sys = ~clk_sys;
   // rails come good one cycle after their enables
   always @(posedge clk_sys) begin
      g11 <= r11;
      g18 <= r18;
      g33 <= r33;
      if (!park_n) saw_park <= 1'b1;
   end
   // revision value arbitrary
   spss_power_sequencer #(.CHIP_REVISION(16'h0000), .RAIL_STEP_CYC(16'd4),
      .RESET_HOLD_CYC(16'd4), .PARK_CYC(16'd4), .DISCH_CYC(16'd4)) dut (
      .clk_sys(clk_sys), .srst(srst), .power_on_request(pon), .main_supply_good(main_ok),
      .rail_1v1_good(g11), .rail_1v8_good(g18), .rail_3v3_good(g33),
      .analog_six_volt_input_good(sup_ok), .die_temp_warning(warn), .die_temp_error(hot),
      .watchdog_one_error(wd1), .watchdog_two_error(wd2), .mirror_rail_power_fault(vx),
      .checksum_error(cks), .primary_serial_clock(p_ck), .primary_spi_select_n(p_sel),
      .primary_serial_mosi(p_mo), .primary_serial_miso(p_mi), .monitor_serial_clock(m_ck),
      .monitor_spi_select_n(m_sel), .monitor_serial_mosi(m_mo), .monitor_serial_miso(m_mi),
      .rail_1v1_en_q(r11), .rail_1v8_en_q(r18), .rail_3v3_en_q(r33), .mirror_reg_en_q(mreg),
      .controller_reset_n_q(crst_n), .park_request_n_q(park_n), .illumination_en_q(illum));
   spss_spi_master u_pri (.sclk(p_ck), .sel_n(p_sel), .mosi(p_mo), .miso(p_mi));
   spss_spi_master u_mon (.sclk(m_ck), .sel_n(m_sel), .mosi(m_mo), .miso(m_mi));
   task summarize;
      if (num_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] frm(input logic w, input logic [5:0] a, input logic [15:0] d);
      return {w, a, ^{w, a}, 8'h00, d};
   endfunction
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      u_mon.xfer(frm(1'b0, a, 16'h0000), d);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      logic [15:0] x;
      u_pri.xfer(frm(1'b1, a, v), x);
   endtask
   // polls the state field a bounded number of times
   task automatic expect_st(input logic [4:0] st);
      logic [15:0] d;
      int n;
      for (n = 0; n < 20; n++) begin
         rd(6'h05, d);
         if (d[4:0] === st) break;
      end
      check({11'h000, d[4:0]}, {11'h000, st});
      if (n == 20) summarize();
   endtask
   task automatic set_pon(input logic v);
      @(posedge clk_sys);
      pon <= v;
   endtask
   task automatic t_reset;
      logic [15:0] d;
      check({11'h000, r11, r18, r33, crst_n, park_n}, 16'h0001);
      rd(6'h05, d);
      check(d, 16'h0002);
      rd(6'h00, d);
      check(d, 16'h0000);
      rd(6'h3f, d);
      check(d, 16'h0000);
      @(posedge clk_sys);
      wd1 <= 1'b1;
      wd2 <= 1'b1;
      cks <= 3'h7;
      repeat (10) @(posedge clk_sys);
      wd1 <= 1'b0;
      wd2 <= 1'b0;
      cks <= 3'h0;
      rd(6'h01, d);
      check(d, 16'h07c1);
   endtask
   task automatic t_power;
      @(posedge clk_sys);
      warn <= 1'b1;
      pon <= 1'b1;
      repeat (100) @(posedge clk_sys);
      check({15'h0000, r11}, 16'h0000);
      warn <= 1'b0;
      expect_st(5'h08);
      check({15'h0000, crst_n}, 16'h0001);
   endtask
   task automatic t_mirror;
      logic [15:0] d;
      u_mon.xfer(frm(1'b1, 6'h02, 16'h0004), d);
      expect_st(5'h08);
      wr(6'h02, 16'h0044);
      expect_st(5'h09);
      wr(6'h02, 16'h004c);
      expect_st(5'h0c);
      wr(6'h02, 16'h005c);
      expect_st(5'h0c);
      check({15'h0000, illum}, 16'h0001);
      wr(6'h02, 16'h001c);
      expect_st(5'h0d);
      wr(6'h02, 16'h000c);
      expect_st(5'h0c);
      wr(6'h02, 16'h001c);
      wr(6'h02, 16'h0002);
      expect_st(5'h08);
      check({14'h0000, saw_park, mreg}, 16'h0002);
      set_pon(1'b0);
      expect_st(5'h02);
      rd(6'h05, d);
      check(d, 16'h0022);
   endtask
   task automatic t_late_off;
      set_pon(1'b1);
      expect_st(5'h08);
      wr(6'h02, 16'h0004);
      expect_st(5'h09);
      set_pon(1'b0);
      repeat (100) @(posedge clk_sys);
      expect_st(5'h09);
      wr(6'h02, 16'h000c);
      expect_st(5'h02);
   endtask
   task automatic t_hot;
      logic [15:0] d;
      wr(6'h02, 16'h0000);
      set_pon(1'b1);
      expect_st(5'h08);
      @(posedge clk_sys);
      hot <= 1'b1;
      warn <= 1'b1;
      expect_st(5'h00);
      check({13'h0000, r11, r18, r33}, 16'h0000);
      @(posedge clk_sys);
      hot <= 1'b0;
      repeat (100) @(posedge clk_sys);
      expect_st(5'h00);
      @(posedge clk_sys);
      pon <= 1'b0;
      warn <= 1'b0;
      expect_st(5'h02);
      rd(6'h05, d);
      check(d, 16'h0082);
      // even parity broken on purpose
      u_pri.xfer(frm(1'b0, 6'h00, 16'h0000) ^ 32'h0100_0000, d);
      wr(6'h01, 16'h0010);
      rd(6'h01, d);
      check(d, 16'h17f7);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_power();
      t_mirror();
      t_late_off();
      t_hot();
      summarize();
   end
endmodule
`default_nettype wire
